//--- swsm_pkg.sv
// package for the swing arm safety monitor: thresholds, timing, carriers
// assumes a 125 MHz system clock and unsigned position samples
package swsm_pkg;
   localparam int ADC_W = 12;
   // position thresholds in sample codes
   localparam logic [ADC_W-1:0] POS_MIN   = 12'h080;
   localparam logic [ADC_W-1:0] POS_MAX   = 12'hf80;
   localparam logic [ADC_W-1:0] AGREE_TOL = 12'h040;
   localparam logic [ADC_W-1:0] RET_ZONE  = 12'h200;
   localparam logic [ADC_W-1:0] DEP_ZONE  = 12'he00;
   // largest change per check interval
   localparam logic [ADC_W-1:0] RATE_SLOW = 12'h004;
   localparam logic [ADC_W-1:0] RATE_FAST = 12'h010;
   // zone codes on the two zone signals
   localparam logic [1:0] ZONE_MID = 2'h0;
   localparam logic [1:0] ZONE_RET = 2'h1;
   localparam logic [1:0] ZONE_DEP = 2'h2;
   // timing
   localparam int CLK_HZ      = 125_000_000;
   localparam int HB_HZ       = 100;
   localparam int HB_HALF_CYC = CLK_HZ / (2 * HB_HZ);
   localparam int CHECK_US    = 1000;
   localparam int CHECK_CYC   = CLK_HZ / 1_000_000 * CHECK_US;
   localparam int STALE_US    = 100;
   localparam int STALE_CYC   = CLK_HZ / 1_000_000 * STALE_US;
   localparam int STAT_MS     = 100;
   localparam int STAT_CYC    = CLK_HZ / 1000 * STAT_MS;
   localparam int FILT_LG     = 2;
   // sample pair from the converters
   typedef struct packed {
      logic             va;
      logic             vb;
      logic [ADC_W-1:0] a;
      logic [ADC_W-1:0] b;
   } swsm_smp_t;
   // status datagram payload
   typedef struct packed {
      logic [31:0]      dest_ip;
      logic [15:0]      dest_port;
      logic             motor_on;
      logic             brakes_on;
      logic [1:0]       zone;
      logic             halted;
      logic             armed;
      logic [ADC_W-1:0] pos_a;
      logic [ADC_W-1:0] pos_b;
   } swsm_stat_t;
   typedef enum logic [1:0] {ST_WAIT, ST_RUN, ST_HALT} swsm_state_t;
endpackage

//--- swsm_filt.sv
// moving average filter for one position channel
// assumes samples arrive as one-cycle valid strobes on clk_i
`timescale 1ns/1ps
module swsm_filt #(
   parameter int LG = swsm_pkg::FILT_LG
) (
   input  wire logic                       clk_i,
   input  wire logic                       nrst_i,
   input  wire logic                       vld_i,
   input  wire logic [swsm_pkg::ADC_W-1:0] smp_i,
   output logic      [swsm_pkg::ADC_W-1:0] avg_o,
   output logic                            full_o
);
   import swsm_pkg::*;
   localparam int N = 1 << LG;
   if (LG < 1 || LG > 6) $error("filter depth out of range");
   logic [ADC_W-1:0]    buf_reg [N];
   logic [ADC_W-1:0]    buf_next [N];
   logic [ADC_W+LG-1:0] sum_reg, sum_next;
   logic [LG-1:0]       ptr_reg, ptr_next;
   logic [LG:0]         cnt_reg, cnt_next;
   logic [ADC_W-1:0]    avg_reg, avg_next;
   // running sum: add newest, drop oldest
   always_comb begin
      buf_next = buf_reg;
      sum_next = sum_reg;
      ptr_next = ptr_reg;
      cnt_next = cnt_reg;
      if (vld_i) begin
         buf_next[ptr_reg] = smp_i;
         sum_next = sum_reg + (ADC_W+LG)'(smp_i)
                  - (ADC_W+LG)'(buf_reg[ptr_reg]);
         ptr_next = ptr_reg + 1'b1;
         if (cnt_reg != (LG+1)'(N))
            cnt_next = cnt_reg + 1'b1;
      end
      avg_next = sum_next[ADC_W+LG-1:LG];
   end
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         for (int i = 0; i < N; i++)
            buf_reg[i] <= '0;
         sum_reg <= '0;
         ptr_reg <= '0;
         cnt_reg <= '0;
         avg_reg <= '0;
      end else begin
         buf_reg <= buf_next;
         sum_reg <= sum_next;
         ptr_reg <= ptr_next;
         cnt_reg <= cnt_next;
         avg_reg <= avg_next;
      end
   end
   assign avg_o  = avg_reg;
   assign full_o = (cnt_reg == (LG+1)'(N));
endmodule // swsm_filt

//--- swsm_mon.sv
// top of the swing arm safety monitor: checks, heartbeat, zones, status
// assumes converter samples on clk_i; status words go to a udp framer
`timescale 1ns/1ps
// Functional notes
// [R1] sample both positions, power and brake inputs
// [R2] toggle heartbeat near 100 Hz while safe
// [R3] outside electronics cut power when heartbeat stops
// [R4] drive two zone signals: retract, deploy, between
// [R5] heartbeat independent of zone output use
// [R6] halt heartbeat on position disagreement
// [R7] halt heartbeat on position out of range
// [R8] halt heartbeat on zone-dependent excess rate
// [R9] halt heartbeat when the check loop stalls
// [R10] fixed logic, runs right after reset
// [R11] filter noisy samples before checking
// [R12] periodic status words only while link up
// [R13] heartbeat static until first full pass
module swsm_mon #(
   parameter int          HB_HALF   = swsm_pkg::HB_HALF_CYC,
   parameter int          CHECK     = swsm_pkg::CHECK_CYC,
   parameter int          STALE     = swsm_pkg::STALE_CYC,
   parameter int          STAT      = swsm_pkg::STAT_CYC,
   parameter logic [31:0] DEST_IP   = 32'hc0a8_0001, // arbitrary
   parameter logic [15:0] DEST_PORT = 16'h1388       // arbitrary
) (
   input  wire logic                 clk_i,
   input  wire logic                 nrst_i,
   input  wire swsm_pkg::swsm_smp_t  smp_i,
   input  wire logic                 motor_on_i,
   input  wire logic                 brakes_on_i,
   input  wire logic                 link_up_i,
   output logic                      hb_o,
   output logic [1:0]                zone_o,
   output logic                      halted_o,
   output logic                      stat_vld_o,
   output swsm_pkg::swsm_stat_t      stat_o
);
   import swsm_pkg::*;
   if (HB_HALF < 2 || CHECK < 2 || STALE < 2 || STAT < 2)
      $error("timing counts too small");
   if (CHECK >= HB_HALF) $error("check interval must beat heartbeat");

   // absolute difference of two positions
   function automatic logic [ADC_W-1:0] absd(input logic [ADC_W-1:0] x,
                                             input logic [ADC_W-1:0] y);
      return (x > y) ? x - y : y - x;
   endfunction
   // zone code for a position
   function automatic logic [1:0] zone_of(input logic [ADC_W-1:0] p);
      if (p < RET_ZONE) return ZONE_RET;
      if (p > DEP_ZONE) return ZONE_DEP;
      return ZONE_MID;
   endfunction

   logic [ADC_W-1:0] fa, fb;
   logic             full_a, full_b;
   // noise filtering of both channels
   swsm_filt u_filt_a (.clk_i(clk_i), .nrst_i(nrst_i), .vld_i(smp_i.va),
      .smp_i(smp_i.a), .avg_o(fa), .full_o(full_a)); // R11
   swsm_filt u_filt_b (.clk_i(clk_i), .nrst_i(nrst_i), .vld_i(smp_i.vb),
      .smp_i(smp_i.b), .avg_o(fb), .full_o(full_b)); // R11

   // pin synchronisers: value taken when stages two and three agree
   logic [2:0] s1_reg, s2_reg, s3_reg, pin_reg, pin_next;
   always_comb begin
      pin_next = pin_reg;
      for (int i = 0; i < 3; i++)
         if (s2_reg[i] == s3_reg[i])
            pin_next[i] = s3_reg[i];
   end
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         s1_reg  <= '0;
         s2_reg  <= '0;
         s3_reg  <= '0;
         pin_reg <= '0;
      end else begin
         s1_reg  <= {link_up_i, brakes_on_i, motor_on_i}; // R1
         s2_reg  <= s1_reg;
         s3_reg  <= s2_reg;
         pin_reg <= pin_next;
      end
   end

   // check loop state
   swsm_state_t      st_reg, st_next;
   logic [31:0]      chk_cnt_reg, chk_cnt_next;
   logic [31:0]      hb_cnt_reg, hb_cnt_next;
   logic [31:0]      sa_reg, sa_next, sb_reg, sb_next;
   logic [31:0]      stc_reg, stc_next;
   logic [ADC_W-1:0] pa_reg, pa_next, pb_reg, pb_next;
   logic             prev_reg, prev_next, seen_reg, seen_next;
   logic             hb_reg, hb_next, sv_reg, sv_next;
   logic             halt_reg, halt_next;
   logic [1:0]       zone_reg, zone_next;
   swsm_stat_t       stat_reg, stat_next;
   logic             tick, stale, e_agree, e_range, e_rate, pass;
   logic [ADC_W-1:0] lim;

   // check conditions: stale acts in any cycle, the others at each loop tick
   always_comb begin
      tick    = (chk_cnt_reg == 32'(CHECK - 1));
      stale   = (sa_reg == 32'(STALE - 1)) || (sb_reg == 32'(STALE - 1));
      e_agree = absd(fa, fb) > AGREE_TOL; // R6
      e_range = (fa < POS_MIN) || (fa > POS_MAX) ||
                (fb < POS_MIN) || (fb > POS_MAX); // R7
      lim     = (zone_of(fa) == ZONE_MID) ? RATE_FAST : RATE_SLOW; // R8
      e_rate  = prev_reg && ((absd(fa, pa_reg) > lim) ||
                             (absd(fb, pb_reg) > lim)); // R8
      pass    = full_a && full_b && !stale && !e_agree && !e_range && !e_rate;
   end

   // loop sequencing, heartbeat, zones and status
   always_comb begin
      st_next      = st_reg;
      chk_cnt_next = tick ? '0 : chk_cnt_reg + 32'h0000_0001;
      sa_next      = smp_i.va ? '0 : (stale ? sa_reg : sa_reg + 32'h0000_0001);
      sb_next      = smp_i.vb ? '0 : (stale ? sb_reg : sb_reg + 32'h0000_0001);
      pa_next      = pa_reg;
      pb_next      = pb_reg;
      prev_next    = prev_reg;
      seen_next    = seen_reg;
      hb_next      = hb_reg;
      hb_cnt_next  = hb_cnt_reg;
      zone_next    = zone_reg;
      stc_next     = (stc_reg == 32'(STAT - 1)) ? '0 : stc_reg + 32'h0000_0001;
      sv_next      = 1'b0;
      stat_next    = stat_reg;
      if (tick) begin
         pa_next   = fa;
         pb_next   = fb;
         prev_next = full_a && full_b;
         zone_next = zone_of(fa); // R4
         if (pass)
            seen_next = 1'b1; // R9
      end
      case (st_reg)
         ST_WAIT: begin
            if (tick && pass && prev_reg) begin
               st_next     = ST_RUN; // R13
               hb_cnt_next = '0; // arming tick already counts as a pass
            end
         end
         ST_RUN: begin
            hb_cnt_next = hb_cnt_reg + 32'h0000_0001;
            if ((tick && !pass) || stale)
               st_next = ST_HALT; // R6 R7 R8
            else if (hb_cnt_reg == 32'(HB_HALF - 1)) begin
               hb_cnt_next = '0;
               seen_next   = tick && pass; // a pass now is not lost
               if (seen_reg)
                  hb_next = !hb_reg; // R2
               else
                  st_next = ST_HALT; // R9
            end
         end
         ST_HALT: st_next = ST_HALT; // latched until reset
         default: st_next = ST_HALT;
      endcase
      halt_next = (st_next == ST_HALT); // R9
      // status word independent of protection path
      if (stc_reg == 32'(STAT - 1) && pin_reg[2]) begin
         sv_next   = 1'b1; // R12
         stat_next = '{dest_ip: DEST_IP, dest_port: DEST_PORT,
                       motor_on: pin_reg[0], brakes_on: pin_reg[1],
                       zone: zone_reg, halted: (st_reg == ST_HALT),
                       armed: (st_reg != ST_WAIT), pos_a: fa, pos_b: fb};
      end
   end

   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         st_reg      <= ST_WAIT; // R10
         chk_cnt_reg <= '0;
         hb_cnt_reg  <= '0;
         sa_reg      <= '0;
         sb_reg      <= '0;
         stc_reg     <= '0;
         pa_reg      <= '0;
         pb_reg      <= '0;
         prev_reg    <= 1'b0;
         seen_reg    <= 1'b0;
         hb_reg      <= 1'b0;
         zone_reg    <= ZONE_MID;
         sv_reg      <= 1'b0;
         halt_reg    <= 1'b0;
         stat_reg    <= '0;
      end else begin
         st_reg      <= st_next;
         chk_cnt_reg <= chk_cnt_next;
         hb_cnt_reg  <= hb_cnt_next;
         sa_reg      <= sa_next;
         sb_reg      <= sb_next;
         stc_reg     <= stc_next;
         pa_reg      <= pa_next;
         pb_reg      <= pb_next;
         prev_reg    <= prev_next;
         seen_reg    <= seen_next;
         hb_reg      <= hb_next;
         zone_reg    <= zone_next;
         sv_reg      <= sv_next;
         halt_reg    <= halt_next;
         stat_reg    <= stat_next;
      end
   end

   // outputs straight from flops; zone path never feeds protection
   assign hb_o       = hb_reg; // R5
   assign zone_o     = zone_reg;
   assign halted_o   = halt_reg;
   assign stat_vld_o = sv_reg;
   assign stat_o     = stat_reg;

   // checks on the protection path, the zone output and the status words
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!nrst_i);
   AST_HB_STATIC: assert property ( // R13
      (st_reg != ST_RUN) |=> $stable(hb_reg))
      else $error("heartbeat moved outside run");
   AST_HB_SPACING: assert property ( // R2
      $changed(hb_reg) |=> !$changed(hb_reg) [*8])
      else $error("heartbeat toggles too fast");
   AST_AGREE_HALT: assert property ( // R6
      (st_reg == ST_RUN && tick && e_agree) |=> (st_reg == ST_HALT))
      else $error("disagreement did not halt");
   AST_RANGE_HALT: assert property ( // R7
      (st_reg == ST_RUN && tick && e_range) |=> (st_reg == ST_HALT))
      else $error("out of range did not halt");
   AST_RATE_HALT: assert property ( // R8
      (st_reg == ST_RUN && tick && e_rate) |=> halted_o)
      else $error("excess rate did not halt");
   AST_STALE_HALT: assert property ( // R9
      (st_reg == ST_RUN && stale) |=> halted_o ##1 $stable(hb_reg))
      else $error("stalled input did not halt");
   AST_ZONE_TRACK: assert property ( // R4
      tick |=> (zone_o == zone_of($past(fa))))
      else $error("zone not updated at tick");
   AST_ARM_CAUSE: assert property ( // R13
      (st_reg == ST_WAIT) ##1 (st_reg == ST_RUN) |->
      $past(tick) && $past(pass) && $past(prev_reg))
      else $error("armed without passing checks");
   AST_STAT_LINK: assert property ( // R12
      stat_vld_o |-> $past(pin_reg[2]))
      else $error("status sent without link");
   AST_HALT_LATCH: assert property ( // R9
      halted_o |=> halted_o)
      else $error("halt released");
   COV_RUN:  cover property ((st_reg == ST_WAIT) ##1 (st_reg == ST_RUN));
   COV_HB:   cover property ($changed(hb_reg));
   COV_HALT: cover property ((st_reg == ST_RUN) ##1 halted_o);
   COV_STAT: cover property (stat_vld_o);
endmodule // swsm_mon

//--- swsm_plant.sv
// far side model: power cut-off electronics watching the heartbeat
// assumes hb_i is the monitor heartbeat on the same clock
`timescale 1ns/1ps
module swsm_plant #(
   parameter int LIMIT = 160
) (
   input  wire logic clk_i,
   input  wire logic nrst_i,
   input  wire logic hb_i,
   input  wire logic run_i,
   output logic      motor_on_o,
   output logic      brakes_on_o
);
   int   idle;
   logic hb_q;
   // count cycles since the heartbeat last changed
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         idle <= LIMIT;
         hb_q <= 1'b0;
      end else begin
         hb_q <= hb_i;
         if (hb_i != hb_q)
            idle <= 0;
         else if (idle < LIMIT)
            idle <= idle + 1;
      end
   end
   // power only while the heartbeat toggles, brakes otherwise
   assign motor_on_o  = run_i && (idle < LIMIT);
   assign brakes_on_o = !motor_on_o;
endmodule // swsm_plant

//--- swsm_mon_tb.sv
// self-checking bench for the safety monitor and its power cut-off model
// assumes shortened timing parameters so each scenario is brief
`timescale 1ns/1ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin n_fail++; \
   $display("BAD t=%0t got %0h exp %0h", $time, g, e); end end
module swsm_mon_tb;
   import swsm_pkg::*;
   localparam logic [11:0] RV [4] = '{12'h07f, 12'h080, 12'hf80, 12'hf81};
   localparam logic [11:0] ZV [3] = '{12'h100, 12'hf00, 12'h800};
   localparam logic [1:0]  ZX [3] = '{ZONE_RET, ZONE_DEP, ZONE_MID};
   localparam logic [31:0] DIP    = 32'h0a00_0102; // arbitrary address
   localparam logic [15:0] DPORT  = 16'h2345;      // arbitrary port
   logic       clk_i, nrst_i, run, link, smp_en, hb, halted, svld;
   logic       motor, brakes;
   logic [1:0] zone;
   logic [11:0] pa, pb;
   swsm_smp_t  smp, v;
   swsm_stat_t stat;
   int         n_fail, total_checks;
   swsm_mon #(.HB_HALF(64), .CHECK(16), .STALE(12), .STAT(50),
      .DEST_IP(DIP), .DEST_PORT(DPORT)) i_swsm_mon (
      .clk_i(clk_i), .nrst_i(nrst_i), .smp_i(smp), .motor_on_i(motor),
      .brakes_on_i(brakes), .link_up_i(link), .hb_o(hb), .zone_o(zone),
      .halted_o(halted), .stat_vld_o(svld), .stat_o(stat));
   swsm_plant i_swsm_plant (.clk_i(clk_i), .nrst_i(nrst_i), .hb_i(hb),
      .run_i(run), .motor_on_o(motor), .brakes_on_o(brakes));
   // clock at 125 MHz
   initial begin
      clk_i = 1'b0;
      forever #4 clk_i = ~clk_i;
   end
   // sample pair every 5 cycles, captured at the edge, applied 1 ns later
   initial begin
      smp = '0;
      forever begin
         repeat (4) @(posedge clk_i);
         v = {smp_en, smp_en, pa, pb};
         #1 smp = v;
         @(posedge clk_i);
         #1 smp = {2'b00, pa, pb};
      end
   end
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask
   task automatic stop_test;
      $display("checks %0d fails %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic do_reset;
      nrst_i = 1'b0;
      cyc(12);
      nrst_i = 1'b1;
   endtask
   task automatic wait_hb(input int lim, output int n);
      logic h;
      h = hb;
      n = 0;
      while (hb === h && n < lim) begin
         cyc(1);
         n++;
      end
   endtask
   task automatic wait_vld(output int n);
      n = 0;
      while (svld !== 1'b1 && n < 120) begin
         cyc(1);
         n++;
      end
      if (n >= 120) begin
         n_fail++;
         $display("BAD t=%0t status word never came", $time);
         stop_test();
      end
   endtask
   task automatic arm(input logic [11:0] a, input logic [11:0] b);
      int n;
      pa = a;
      pb = b;
      smp_en = 1'b1;
      do_reset();
      wait_hb(400, n);
      if (n >= 400) begin
         n_fail++;
         $display("BAD t=%0t heartbeat never started", $time);
         stop_test();
      end
   endtask
   // reset values, then a static heartbeat before the first pass
   task automatic t_reset;
      pa = 12'h800;
      pb = 12'h800;
      do_reset();
      `CHK(hb, 1'b0)
      `CHK(zone, ZONE_MID)
      cyc(40);
      `CHK(hb, 1'b0)
      $display("done reset");
   endtask
   // steady toggle period, zones, and a zone-dependent rate step
   task automatic t_zone;
      int n;
      for (int i = 0; i < 3; i++) begin
         arm(ZV[i], ZV[i]);
         wait_hb(200, n);
         `CHK(n, 64)
         `CHK(zone, ZX[i])
         pa = ZV[i] + 12'h00c;
         pb = ZV[i] + 12'h00c;
         cyc(100);
         `CHK(halted, (i < 2))
      end
      $display("done zone");
   endtask
   // range limits are inclusive, outside values never arm
   task automatic t_range;
      int n;
      for (int i = 0; i < 4; i++) begin
         pa = RV[i];
         pb = RV[i];
         do_reset();
         wait_hb(300, n);
         `CHK(n < 300, (i == 1 || i == 2))
      end
      // a position drifting just below range while running halts
      arm(12'h080, 12'h080);
      pa = 12'h07f;
      pb = 12'h07f;
      cyc(60);
      `CHK(halted, 1'b1)
      $display("done range");
   endtask
   // tolerance boundary arms, a wider gap halts for good
   task automatic t_agree;
      int n;
      arm(12'h800, 12'h840);
      pb = 12'h848;
      cyc(100);
      `CHK(halted, 1'b1)
      wait_hb(200, n);
      `CHK(n, 200)
      $display("done agree");
   endtask
   // a single noisy sample is smoothed out
   task automatic t_noise;
      arm(12'h800, 12'h800);
      pa = 12'h820;
      cyc(5); // one sample slot: exactly one noisy sample
      pa = 12'h800;
      cyc(100);
      `CHK(halted, 1'b0)
      $display("done noise");
   endtask
   // status words: none while link down, then every 50 cycles
   task automatic t_stat;
      int n;
      int k;
      arm(12'h800, 12'h800);
      k = 0;
      for (int i = 0; i < 150; i++) begin
         cyc(1);
         k += (svld === 1'b1);
      end
      `CHK(k, 0)
      link = 1'b1;
      wait_vld(n);
      `CHK(svld, 1'b1)
      `CHK(stat.dest_ip, DIP)
      `CHK(stat.dest_port, DPORT)
      `CHK(stat.pos_a, 12'h800)
      `CHK(stat.pos_b, 12'h800)
      `CHK(stat.zone, ZONE_MID)
      `CHK(stat.armed, 1'b1)
      `CHK(stat.halted, 1'b0)
      `CHK(stat.motor_on, 1'b1)
      `CHK(stat.brakes_on, 1'b0)
      cyc(1);
      wait_vld(n);
      `CHK(n + 1, 50)
      $display("done stat");
   endtask
   // stalled samples halt, the far side cuts power, status shows it
   task automatic t_stall;
      int n;
      arm(12'h800, 12'h800);
      smp_en = 1'b0;
      cyc(40);
      `CHK(halted, 1'b1)
      wait_hb(200, n);
      `CHK(n, 200)
      cyc(20);
      wait_vld(n);
      `CHK(stat.halted, 1'b1)
      `CHK(stat.motor_on, 1'b0)
      $display("done stall");
   endtask
   // main sequence
   initial begin
      n_fail = 0;
      total_checks = 0;
      nrst_i = 1'b0;
      run = 1'b1;
      link = 1'b0;
      smp_en = 1'b1;
      pa = 12'h800;
      pb = 12'h800;
      t_reset();
      t_zone();
      t_range();
      t_agree();
      t_noise();
      t_stat();
      t_stall();
      stop_test();
   end
endmodule // swsm_mon_tb
